// File: feedback_model.sv
// behavioural secondary-side feedback model driving the enable pin
`timescale 1ns/1ps
`default_nettype none
module feedback_model (
	// clock
	input  wire logic       core_clk,
	// output level seen on the secondary and response lag in cycles
	input  wire logic       above_ref,
	input  wire logic [3:0] lag,
	// enable pin drive
	output var  logic       enable_pin
);
	// ==========================================================
	// optocoupler delay line
	logic [15:0] hist_ff = 16'hffff;

	// slow transistor response modelled as a shift line, so late answers get exercised
	always_ff @(posedge core_clk) begin
		hist_ff <= {hist_ff[14:0], !above_ref};
	end

	// high while the output is below target, pulled low above it
	assign enable_pin = (lag == 4'h0) ? !above_ref : hist_ff[lag - 4'h1];
endmodule : feedback_model
`default_nettype wire

// File: on_off_switch_cycle_control_bench.sv
// self-checking bench for the on/off switching-cycle controller
`timescale 1ns/1ps
`default_nettype none
module on_off_switch_cycle_control_bench;
	// ==========================================================
	// signals and expectation notes
	localparam int PER  = switch_cycle_pkg::OSC_PERIOD_CYC;
	localparam int DUTY = switch_cycle_pkg::MAX_DUTY_CYC;
	localparam bit EN_T [13] = '{1, 1, 1, 0, 1, 0, 0, 0, 0, 1, 1, 1, 0};
	localparam int LIM_T [13] = '{200, 200, 1200, 0, 200, 0, 0, 0, 0, 200, 10, 85, 0};
	typedef struct packed {
		logic        pulse;
		logic [1:0]  level;
		logic [15:0] lo;
		logic [15:0] hi;
		logic [15:0] per;
	} note_s;
	logic                      core_clk;
	logic                      resetn;
	logic                      above_ref;
	logic [3:0]                lag;
	logic                      enable_pin;
	logic                      line_ok_in;
	logic                      line_sense_present;
	logic                      drain_limit_hit;
	logic [1:0]                supply_select_pin;
	logic                      power_switch_on;
	logic                      max_duty_signal;
	logic                      cycle_start;
	logic                      switching_suspended;
	switch_cycle_pkg::ilimit_s ilimit;
	switch_cycle_pkg::ilimit_s ilimit_small;
	int                        n_mismatch = 0;
	int                        checks_done = 0;
	int                        skips = 0;
	logic [15:0]               rnd = 16'hb0c8;
	logic [15:0]               on_len = 16'h0;
	logic [15:0]               per_len = 16'h0;
	logic [15:0]               duty_len = 16'h0;
	logic [1:0]                lvl_seen = 2'h0;
	note_s                     exp_q[$];

	feedback_model opto (.core_clk(core_clk), .above_ref(above_ref), .lag(lag),
		.enable_pin(enable_pin));
	switch_cycle_ctrl #(.FAULT_CYCLES(8), .RESTART_CYCLES(16), .LIGHT_SKIPS(4)) dut (
		.core_clk(core_clk), .resetn(resetn), .enable_line_sense_input(enable_pin),
		.line_ok_in(line_ok_in), .line_sense_present(line_sense_present),
		.drain_limit_hit(drain_limit_hit), .supply_select_pin(supply_select_pin),
		.power_switch_on(power_switch_on), .max_duty_signal(max_duty_signal),
		.cycle_start(cycle_start), .ilimit(ilimit), .switching_suspended(switching_suspended));
	// smallest member: only its strap decode is watched
	switch_cycle_ctrl #(.SMALL_MEMBER(1'b1)) dut_small (
		.core_clk(core_clk), .resetn(resetn), .enable_line_sense_input(enable_pin),
		.line_ok_in(line_ok_in), .line_sense_present(line_sense_present),
		.drain_limit_hit(drain_limit_hit), .supply_select_pin(supply_select_pin),
		.power_switch_on(), .max_duty_signal(), .cycle_start(), .ilimit(ilimit_small),
		.switching_suspended());

	// ==========================================================
	// helpers
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next

	task automatic chk(input logic [3:0] got, input logic [3:0] want, input string what);
		checks_done++;
		if (got !== want) begin
			n_mismatch++;
			$display("BAD t=%0t %s got %h want %h", $time, what, got, want);
		end
	endtask : chk

	task automatic chk_period(input note_s e, input logic [15:0] len, input logic [15:0] pl,
			input logic [1:0] lvl);
		checks_done++;
		if ((len != 16'h0) !== e.pulse || pl !== e.per || (e.pulse && (len < e.lo
				|| len > e.hi || (e.level != 2'h2 && lvl !== e.level)))) begin
			n_mismatch++;
			$display("BAD t=%0t period on=%0d len=%0d lvl=%h", $time, len, pl, lvl);
		end
	endtask : chk_period

	task automatic chk_duty(input logic [15:0] len);
		checks_done++;
		if (len !== 16'(DUTY)) begin
			n_mismatch++;
			$display("BAD t=%0t max duty window %0d", $time, len);
		end
	endtask : chk_duty

	task automatic results(input logic hung);
		if (hung) begin
			n_mismatch++;
			$display("BAD t=%0t wait ran out", $time);
		end
		$display("counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results

	// bounded wait for the next cycle start, seen at a falling edge
	task automatic wait_start();
		int t;
		@(negedge core_clk);
		for (t = 0; t < 3100 && cycle_start !== 1'b1; t++)
			@(negedge core_clk);
		if (t == 3100) results(1'b1);
	endtask : wait_start

	// one period: enable set just before its start, limit trips lim cycles into the pulse
	task automatic period(input logic en, input int lim, input bit care);
		note_s n;
		int t;
		above_ref = !en;
		wait_start();
		n.pulse = en;
		n.level = !care ? 2'h2 : (skips == 0) ? switch_cycle_pkg::LVL_FULL
			: (skips < 4) ? switch_cycle_pkg::LVL_MED : switch_cycle_pkg::LVL_LOW;
		skips = en ? 0 : skips + 1;
		n.lo = (lim == 0 || lim > DUTY) ? 16'(DUTY - 2) : 16'(lim + 2);
		n.hi = (lim == 0 || lim > DUTY) ? 16'(DUTY + 2) : 16'(lim + 8);
		n.per = (en && lim != 0 && lim + 8 < 80) ? 16'(2 * PER) : 16'(PER);
		for (t = 0; t < n.per - 20; t++) begin
			@(negedge core_clk);
			rnd = lfsr_next(rnd);
			if (t == 300) above_ref = rnd[0]; // mid-cycle change must be ignored
			drain_limit_hit = lim != 0 && power_switch_on === 1'b1 && t >= lim;
		end
		drain_limit_hit = 1'b0;
		// noted only now, so the monitor pairs it with the period just run
		exp_q.push_back(n);
	endtask : period

	// ==========================================================
	// monitor: closes each period at the next cycle start
	always @(posedge core_clk) begin
		if (resetn === 1'b1 && cycle_start === 1'b1) begin
			if (exp_q.size() > 0) begin
				chk_period(exp_q.pop_front(), on_len, per_len, lvl_seen);
				chk_duty(duty_len);
			end
			on_len = 16'h0;
			per_len = 16'h1;
			duty_len = 16'h0;
		end else begin
			per_len++;
			if (max_duty_signal === 1'b1) duty_len++;
			if (power_switch_on === 1'b1 && on_len == 16'h0) lvl_seen = ilimit.level;
			if (power_switch_on === 1'b1) on_len++;
		end
	end

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = !core_clk;
	end

	// ==========================================================
	// main sequence
	initial begin : main
		int i;
		int t;
		resetn = 1'b0;
		above_ref = 1'b1;
		lag = 4'h1;
		line_ok_in = 1'b0;
		line_sense_present = 1'b1;
		drain_limit_hit = 1'b0;
		supply_select_pin = 2'h0;
		// every strap code under its own reset; later strap changes must not count
		for (i = 0; i < 4; i++) begin
			resetn = 1'b0;
			supply_select_pin = i[1:0];
			repeat (8) @(negedge core_clk);
			chk({power_switch_on, switching_suspended, ilimit.level}, 4'h4, "reset state");
			resetn = 1'b1;
			repeat (2) @(negedge core_clk);
			rnd = lfsr_next(rnd);
			supply_select_pin = rnd[1:0];
			repeat (2) @(negedge core_clk);
			chk({2'h0, ilimit.option}, (i == 0) ? 4'h0 : (i == 1) ? 4'h1 : 4'h2, "option");
			chk({2'h0, ilimit_small.option}, (i == 1) ? 4'h1 : 4'h0, "small option");
		end
		$display("test strap options done");
		// line too low at power up: nothing switches though enable asks for it
		above_ref = 1'b0;
		for (t = 0; t < 3 * PER && power_switch_on === 1'b0; t++)
			@(negedge core_clk);
		chk({3'h0, power_switch_on}, 4'h0, "switching under line uv");
		chk({3'h0, switching_suspended}, 4'h1, "left wait early");
		line_ok_in = 1'b1;
		wait_start();
		wait_start();
		$display("test line power-up done");
		for (i = 0; i < 13; i++)
			period(EN_T[i], LIM_T[i], i != 0);
		$display("test fixed loads done");
		// random loads behind a slow feedback path
		lag = 4'hc;
		for (i = 0; i < 8; i++) begin
			rnd = lfsr_next(rnd);
			period(rnd[0] && (i % 4 != 3), 100 + int'(rnd[9:1]), 1'b1);
		end
		wait_start();
		$display("test random loads done");
		// feedback lost: enable stays high until the fault counter stops switching
		lag = 4'h1;
		above_ref = 1'b0;
		for (t = 0; t < 10 * PER && switching_suspended !== 1'b1; t++)
			@(negedge core_clk);
		if (t == 10 * PER) results(1'b1);
		line_ok_in = 1'b0;
		i = 0;
		for (t = 0; t < 30 * PER && switching_suspended === 1'b1; t++) begin
			@(negedge core_clk);
			if (t == 4 * PER) line_ok_in = 1'b1;
			// the pulse started at expiry runs to its end first
			if (t > DUTY && power_switch_on !== 1'b0) i++;
		end
		if (t == 30 * PER) results(1'b1);
		chk({3'h0, i == 0}, 4'h1, "switching while suspended");
		chk({3'h0, t >= 18 * PER && t <= 21 * PER}, 4'h1, "restart pause");
		$display("test fault restart done");
		results(1'b0);
	end
endmodule : on_off_switch_cycle_control_bench
`default_nettype wire

// File: switch_cycle_ctrl.sv
// on/off switching-cycle controller with current-limit state machine and auto-restart
`timescale 1ns/1ps
`default_nettype none

// Function
// - an enabled cycle turns the power switch on at the oscillator cycle start.
// - the switch turns off at the active current limit or at the end of max duty, first wins.
// - the oscillator runs freely and the enable input is sampled at every cycle start.
// - a started cycle completes whatever the enable input does meanwhile.
// - the current-limit level follows the pattern of enable samples, highest at heavy load.
// - skipped cycles step the limit down once, a long run of skips steps it down again.
// - a current-limit turn-off less than 400 ns into the conduction doubles the running oscillator period.
// - with line sensing, switching goes on 64 ms after regulation loss, then stays off during UV.
// - with line sensing, no switching happens at power up until the line is sufficient.
// - the supply select strap sets the base limit option; the small member has no increase.
// - a low start-of-cycle enable sample keeps the switch off for the whole cycle.
// - an oscillator-clocked fault counter clears on each low enable and suspends on expiry.
// - after expiry switching pauses 2.5 s, longer while line undervoltage persists.
// - the oscillator averages 132 kHz and gives a cycle start and a max-duty signal.
module switch_cycle_ctrl #(
	parameter bit          SMALL_MEMBER = 1'b0,
	parameter int unsigned FAULT_CYCLES   = switch_cycle_pkg::FAULT_OSC,
	parameter int unsigned RESTART_CYCLES = switch_cycle_pkg::RESTART_OSC,
	parameter int unsigned LIGHT_SKIPS    = switch_cycle_pkg::LIGHT_SKIPS
) (
	// clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      resetn,
	// pins from outside the clock domain
	input  wire logic                      enable_line_sense_input,
	input  wire logic                      line_ok_in,
	input  wire logic                      line_sense_present,
	input  wire logic                      drain_limit_hit,
	input  wire logic [1:0]                supply_select_pin,
	// switch drive and status
	output logic                           power_switch_on,
	output logic                           max_duty_signal,
	output logic                           cycle_start,
	output switch_cycle_pkg::ilimit_s      ilimit,
	output logic                           switching_suspended
);

	// ==========================================================
	// pin synchronisers: a change counts once stages two and three agree
	logic [switch_cycle_pkg::PIN_COUNT-1:0] s1_ff;
	logic [switch_cycle_pkg::PIN_COUNT-1:0] s2_ff;
	logic [switch_cycle_pkg::PIN_COUNT-1:0] s3_ff;
	logic [switch_cycle_pkg::PIN_COUNT-1:0] filt_ff;
	wire  [switch_cycle_pkg::PIN_COUNT-1:0] pins_w = {drain_limit_hit, line_sense_present,
		line_ok_in, enable_line_sense_input};

	genvar gi;
	generate
		for (gi = 0; gi < switch_cycle_pkg::PIN_COUNT; gi++) begin : g_sync
			always_ff @(posedge core_clk or negedge resetn) begin
				if (!resetn) begin
					// all stages share one reset level, so release makes no false change
					s1_ff[gi]   <= switch_cycle_pkg::PIN_RESET[gi];
					s2_ff[gi]   <= switch_cycle_pkg::PIN_RESET[gi];
					s3_ff[gi]   <= switch_cycle_pkg::PIN_RESET[gi];
					filt_ff[gi] <= switch_cycle_pkg::PIN_RESET[gi];
				end else begin
					s1_ff[gi] <= pins_w[gi];
					s2_ff[gi] <= s1_ff[gi];
					s3_ff[gi] <= s2_ff[gi];
					if (s2_ff[gi] == s3_ff[gi]) begin
						filt_ff[gi] <= s3_ff[gi];
					end
				end
			end
		end
	endgenerate

	// enable follows the external feedback level
	wire en_w      = filt_ff[switch_cycle_pkg::PIN_EN];
	wire ilim_w    = filt_ff[switch_cycle_pkg::PIN_ILIM];
	wire line_uv_w = filt_ff[switch_cycle_pkg::PIN_SENSE] & ~filt_ff[switch_cycle_pkg::PIN_LINE_OK];

	// ==========================================================
	// oscillator: free running, stretched to double period after a short pulse
	localparam logic [11:0] PERIOD = 12'(switch_cycle_pkg::OSC_PERIOD_CYC);
	localparam logic [11:0] DUTY   = 12'(switch_cycle_pkg::MAX_DUTY_CYC);
	localparam logic [11:0] MIN_ON = 12'(switch_cycle_pkg::MIN_ON_CYC);
	localparam logic [23:0] FAULT_LAST   = 24'(FAULT_CYCLES - 1);
	localparam logic [23:0] RESTART_LAST = 24'(RESTART_CYCLES - 1);
	localparam logic [3:0]  LIGHT        = 4'(LIGHT_SKIPS);

	logic [11:0] osc_cnt_ff;
	logic        slow_ff;
	logic        duty_ff;
	wire  [11:0] period_len_w = slow_ff ? 12'(PERIOD << 1) : PERIOD;
	wire         period_end_w = (osc_cnt_ff == period_len_w - 12'h001);
	wire         cyc_start_w  = (osc_cnt_ff == 12'h000);
	wire         duty_w       = (osc_cnt_ff < DUTY);

	// ==========================================================
	// gate drive
	logic        on_ff;
	logic [11:0] on_cnt_ff;
	switch_cycle_pkg::ctrl_state_e state_ff;
	wire run_w      = (state_ff == switch_cycle_pkg::ST_RUN);
	wire turn_on_w  = cyc_start_w & en_w & run_w;
	wire turn_off_w = on_ff & (ilim_w | ~duty_w);
	wire short_w    = turn_off_w & ilim_w & (on_cnt_ff < MIN_ON);

	// counter wraps at the end of the (possibly stretched) period
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			osc_cnt_ff <= 12'h000;
			slow_ff    <= 1'b0;
			duty_ff    <= 1'b0;
		end else begin
			osc_cnt_ff <= period_end_w ? 12'h000 : osc_cnt_ff + 12'h001;
			duty_ff    <= duty_w;
			if (short_w) begin
				slow_ff <= 1'b1;
			end else if (period_end_w) begin
				slow_ff <= 1'b0;
			end
		end
	end

	// enable is looked at only on cycle start, so mid-cycle changes are ignored
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			on_ff     <= 1'b0;
			on_cnt_ff <= 12'h000;
		end else begin
			if (turn_on_w) begin
				on_ff     <= 1'b1;
				on_cnt_ff <= 12'h000;
			end else if (turn_off_w) begin
				on_ff <= 1'b0;
			end else if (on_ff) begin
				on_cnt_ff <= on_cnt_ff + 12'h001;
			end
		end
	end

	// ==========================================================
	// current-limit level: decided from the run of skipped cycles
	logic [3:0] skip_cnt_ff;
	switch_cycle_pkg::limit_level_e level_ff;
	switch_cycle_pkg::limit_level_e nxt_level;
	assign nxt_level = (skip_cnt_ff == 4'h0) ? switch_cycle_pkg::LVL_FULL :
		(skip_cnt_ff < LIGHT) ? switch_cycle_pkg::LVL_MED : switch_cycle_pkg::LVL_LOW;

	// level moves only on an enabled cycle start, never inside a pulse
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			skip_cnt_ff <= 4'h0;
			level_ff    <= switch_cycle_pkg::LEVEL_RESET;
		end else if (cyc_start_w) begin
			if (en_w) begin
				level_ff    <= nxt_level;
				skip_cnt_ff <= 4'h0;
			end else if (skip_cnt_ff != 4'hf) begin
				skip_cnt_ff <= skip_cnt_ff + 4'h1;
			end
		end
	end

	// ==========================================================
	// supply strap: three synchroniser stages, then caught once after reset release
	logic [1:0]                      strap_s1_ff;
	logic [1:0]                      strap_s2_ff;
	logic [1:0]                      strap_s3_ff;
	logic                            strap_done_ff;
	switch_cycle_pkg::limit_option_e option_ff;
	switch_cycle_pkg::limit_option_e nxt_option;
	assign nxt_option = (strap_s3_ff == 2'h0) ? switch_cycle_pkg::OPT_STD :
		(strap_s3_ff == 2'h1) ? switch_cycle_pkg::OPT_RED :
		(SMALL_MEMBER ? switch_cycle_pkg::OPT_STD : switch_cycle_pkg::OPT_INC);

	// no reset here: the stages must track the strap while reset is held
	always_ff @(posedge core_clk) begin
		strap_s1_ff <= supply_select_pin;
		strap_s2_ff <= strap_s1_ff;
		strap_s3_ff <= strap_s2_ff;
	end

	// taken only when the last two stages agree, never from a metastable stage
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			strap_done_ff <= 1'b0;
			option_ff     <= switch_cycle_pkg::OPTION_RESET;
		end else if (!strap_done_ff && (strap_s2_ff == strap_s3_ff)) begin
			strap_done_ff <= 1'b1;
			option_ff     <= nxt_option;
		end
	end

	// ==========================================================
	// fault counter and auto-restart share one oscillator-cycle counter; the power-up wait only holds the state
	logic [23:0] ev_cnt_ff;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_ff  <= switch_cycle_pkg::ST_WAIT_LINE;
			ev_cnt_ff <= 24'h000000;
		end else if (cyc_start_w) begin
			case (state_ff)
				switch_cycle_pkg::ST_WAIT_LINE: begin
					if (!line_uv_w) begin
						state_ff <= switch_cycle_pkg::ST_RUN;
					end
				end
				switch_cycle_pkg::ST_RUN: begin
					// line UV does not stop switching here; the counter ends it
					if (!en_w) begin
						ev_cnt_ff <= 24'h000000;
					end else if (ev_cnt_ff == FAULT_LAST) begin
						state_ff  <= switch_cycle_pkg::ST_SUSPEND;
						ev_cnt_ff <= 24'h000000;
					end else begin
						ev_cnt_ff <= ev_cnt_ff + 24'h000001;
					end
				end
				switch_cycle_pkg::ST_SUSPEND: begin
					// counter stops while the line is low, stretching the pause
					if (line_uv_w) begin
						ev_cnt_ff <= ev_cnt_ff;
					end else if (ev_cnt_ff >= RESTART_LAST) begin
						state_ff  <= switch_cycle_pkg::ST_RUN;
						ev_cnt_ff <= 24'h000000;
					end else begin
						ev_cnt_ff <= ev_cnt_ff + 24'h000001;
					end
				end
				default: begin
					state_ff <= switch_cycle_pkg::ST_WAIT_LINE;
				end
			endcase
		end
	end

	// ==========================================================
	// outputs
	assign power_switch_on     = on_ff;
	assign max_duty_signal     = duty_ff;
	assign cycle_start         = cyc_start_w;
	assign ilimit              = '{option: option_ff, level: level_ff};
	assign switching_suspended = ~run_w;

	// ==========================================================
	// assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	property p_on_at_start;
		cyc_start_w && en_w && run_w |=> on_ff;
	endproperty
	a_on_at_start: assert property (p_on_at_start) else $error("enabled cycle did not turn on");

	property p_off_at_limit;
		on_ff && !cyc_start_w && (ilim_w || !duty_w) |=> !on_ff;
	endproperty
	a_off_at_limit: assert property (p_off_at_limit) else $error("switch stayed on past limit");

	property p_finish_cycle;
		on_ff && !cyc_start_w && !ilim_w && duty_w |=> on_ff;
	endproperty
	a_finish_cycle: assert property (p_finish_cycle) else $error("pulse cut short");

	property p_skip_off;
		cyc_start_w && !en_w && !on_ff |=> !on_ff [*8];
	endproperty
	a_skip_off: assert property (p_skip_off) else $error("disabled cycle switched");

	property p_level_boundary;
		!$past(cyc_start_w) |-> $stable(level_ff);
	endproperty
	a_level_boundary: assert property (p_level_boundary) else $error("level moved mid-cycle");

	property p_light_level;
		cyc_start_w && en_w && skip_cnt_ff >= LIGHT |=> level_ff == switch_cycle_pkg::LVL_LOW;
	endproperty
	a_light_level: assert property (p_light_level) else $error("light load level wrong");

	property p_short_slow;
		$fell(on_ff) && $past(short_w) |-> slow_ff;
	endproperty
	a_short_slow: assert property (p_short_slow) else $error("short pulse not slowed");

	property p_fault_expire;
		run_w && cyc_start_w && en_w && ev_cnt_ff == FAULT_LAST
			|=> state_ff == switch_cycle_pkg::ST_SUSPEND;
	endproperty
	a_fault_expire: assert property (p_fault_expire) else $error("fault expiry missed");

	property p_no_switch_idle;
		!run_w && !on_ff |=> !on_ff;
	endproperty
	a_no_switch_idle: assert property (p_no_switch_idle) else $error("switched while idle");

	property p_small_no_inc;
		strap_done_ff && SMALL_MEMBER |-> option_ff != switch_cycle_pkg::OPT_INC;
	endproperty
	a_small_no_inc: assert property (p_small_no_inc) else $error("small member increased");

	c_pulse:   cover property (cyc_start_w && turn_on_w ##[1:300] !on_ff);
	c_low_lvl: cover property (level_ff == switch_cycle_pkg::LVL_LOW);
	c_suspend: cover property (state_ff == switch_cycle_pkg::ST_SUSPEND);

endmodule : switch_cycle_ctrl

`default_nettype wire

// File: switch_cycle_pkg.sv
// constants and types shared by the on/off switching-cycle controller
package switch_cycle_pkg;

	// ==========================================================
	// clock and oscillator timing
	localparam int unsigned CLK_HZ         = 200_000_000;
	localparam int unsigned OSC_HZ         = 132_000;
	localparam int unsigned OSC_PERIOD_CYC = CLK_HZ / OSC_HZ;
	localparam int unsigned MAX_DUTY_PCT   = 65;
	localparam int unsigned MAX_DUTY_CYC   = OSC_PERIOD_CYC * MAX_DUTY_PCT / 100;
	localparam int unsigned MIN_ON_NS      = 400;
	// least time: round up to whole core cycles
	localparam int unsigned MIN_ON_CYC     = (MIN_ON_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	// fault and restart times, counted in oscillator cycles
	localparam int unsigned FAULT_MS       = 64;
	localparam int unsigned FAULT_OSC      = FAULT_MS * OSC_HZ / 1000;
	localparam int unsigned RESTART_MS     = 2500;
	localparam int unsigned RESTART_OSC    = RESTART_MS * OSC_HZ / 1000;
	localparam int unsigned LIGHT_SKIPS    = 4;

	// ==========================================================
	// pin input positions in the synchroniser vector
	localparam int unsigned PIN_EN      = 0;
	localparam int unsigned PIN_LINE_OK = 1;
	localparam int unsigned PIN_SENSE   = 2;
	localparam int unsigned PIN_ILIM    = 3;
	localparam int unsigned PIN_COUNT   = 4;
	// sense is taken as fitted until the pin says otherwise, so power up waits for the line
	localparam logic [PIN_COUNT-1:0] PIN_RESET = 4'h4;

	// ==========================================================
	// types
	typedef enum logic [1:0] {LVL_FULL = 2'h0, LVL_MED = 2'h1, LVL_LOW = 2'h3} limit_level_e;
	typedef enum logic [1:0] {OPT_STD = 2'h0, OPT_RED = 2'h1, OPT_INC = 2'h2} limit_option_e;
	typedef enum logic [1:0] {ST_WAIT_LINE = 2'h0, ST_RUN = 2'h1, ST_SUSPEND = 2'h3} ctrl_state_e;
	typedef struct packed {
		limit_option_e option;
		limit_level_e  level;
	} ilimit_s;

	localparam limit_option_e OPTION_RESET = OPT_STD;
	localparam limit_level_e  LEVEL_RESET  = LVL_FULL;

endpackage : switch_cycle_pkg
